// [hw/sssl_pkg.sv]
// Package of constants and carrier types for the servo status and stop logic.
package sssl_pkg;
  localparam int SPD_W = 16;
  localparam int POS_W = 32;
  localparam int MS_W = 12;
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam logic [14:0] DONE_RANGE_RST = 15'h000A;
  localparam logic [14:0] DONE_HYST_RST = 15'h0005;
  localparam logic [14:0] APPROACH_RANGE_RST = 15'h01F4;
  localparam logic [14:0] APPROACH_HYST_RST = 15'h0032;
  localparam logic signed [15:0] SPEED_REACH_RST = 16'sh01F4;
  localparam logic [15:0] SPEED_HYST_RST = 16'h001E;
  localparam logic signed [15:0] TORQUE_REACH_RST = 16'sh0064;
  localparam logic [15:0] TORQUE_HYST_RST = 16'h0005;
  localparam logic [15:0] ZERO_POINT_RST = 16'h000A;
  localparam logic [15:0] ZERO_HYST_RST = 16'h0005;
  localparam logic [15:0] STATIC_POINT_RST = 16'h0005;
  localparam logic [11:0] STANDSTILL_DELAY_MS = 12'h096;
  localparam logic [11:0] RUN_WAIT_MS = 12'h000;
  localparam logic [15:0] RUN_BRAKE_SPEED_RST = 16'h0064;
  localparam logic [11:0] DYN_DELAY_MS_RST = 12'h064;
  localparam logic [1:0] ESTOP_COAST = 2'h0;
  localparam logic [1:0] ESTOP_RAMP = 2'h1;
  localparam logic [1:0] ESTOP_DECEL = 2'h2;

  typedef struct packed {
    logic [14:0] done_range;
    logic [14:0] done_hysteresis;
    logic [14:0] approach_range;
    logic [14:0] approach_hysteresis;
    logic signed [15:0] speed_reach_threshold;
    logic [15:0] speed_reach_hysteresis;
    logic speed_reach_polarity;
    logic signed [15:0] torque_reach_threshold;
    logic [15:0] torque_reach_hysteresis;
    logic torque_reach_polarity;
    logic [15:0] zero_speed_point;
    logic [15:0] zero_speed_hysteresis;
    logic zero_hold_mode;
    logic deviation_clear_mode;
    logic [1:0] emergency_stop_mode;
    logic [15:0] static_speed_point;
    logic [11:0] standstill_brake_delay;
    logic [11:0] running_brake_wait;
    logic [15:0] running_brake_speed;
    logic [11:0] dyn_brake_delay;
  } sssl_cfg_t;

  typedef enum logic [1:0] {
    SSSL_OFF = 2'b00,
    SSSL_ON = 2'b01,
    SSSL_STOP_STILL = 2'b10,
    SSSL_STOP_RUN = 2'b11
  } sssl_state_t;
endpackage : sssl_pkg

// [hw/sssl_top.sv]
// Status comparators, zero clamp, deviation clear, emergency stop and brake sequencing.
`timescale 1ns/1ps
module sssl_top #(
  parameter int CYC_PER_MS = sssl_pkg::CYC_PER_MS
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire sssl_pkg::sssl_cfg_t cfg_in,
  input wire logic pos_mode_in,
  input wire logic speed_mode_in,
  input wire logic signed [31:0] deviation_in,
  input wire logic signed [15:0] motor_speed_in,
  input wire logic signed [15:0] motor_torque_in,
  input wire logic signed [15:0] speed_cmd_in,
  input wire logic signed [31:0] motor_pos_in,
  input wire logic zero_hold_input,
  input wire logic deviation_clear_input,
  input wire logic emergency_stop_input,
  input wire logic servo_on_input,
  input wire logic alarm_in,
  output logic position_done_flag,
  output logic near_position_flag,
  output logic speed_reached_flag,
  output logic torque_reached_flag,
  output logic standstill_speed_flag,
  output logic clamp_active_out,
  output logic clamp_pos_hold_out,
  output logic signed [31:0] clamp_pos_out,
  output logic signed [15:0] speed_cmd_out,
  output logic deviation_clear_out,
  output logic current_on_out,
  output logic ramp_stop_out,
  output logic dyn_brake_en_out,
  output logic brake_release_output
);
  localparam int CW = 32;

  // Hysteresis band: set when at or below the point, release only past point plus hysteresis.
  function automatic logic below_hyst(input logic [31:0] mag, input logic [31:0] pt,
                                      input logic [31:0] hy, input logic cur);
    below_hyst = cur ? (mag <= pt + hy) : (mag <= pt);
  endfunction : below_hyst

  // Above-threshold band with hysteresis on the release side.
  function automatic logic above_hyst(input logic signed [31:0] v, input logic signed [31:0] th,
                                      input logic signed [31:0] hy, input logic cur);
    above_hyst = cur ? (v > th - hy) : (v > th);
  endfunction : above_hyst

  function automatic logic [31:0] abs32(input logic signed [31:0] v);
    abs32 = v[31] ? 32'(-v) : 32'(v);
  endfunction : abs32

  // Signed level compare with polarity: either direction, or the sign of the threshold only.
  function automatic logic reach_cmp(input logic signed [31:0] v, input logic signed [31:0] th,
                                     input logic signed [31:0] hy, input logic pol, input logic cur);
    if (!pol) reach_cmp = above_hyst($signed(abs32(v)), $signed(abs32(th)), hy, cur);
    else if (!th[31]) reach_cmp = above_hyst(v, th, hy, cur);
    else reach_cmp = above_hyst(-v, -th, hy, cur);
  endfunction : reach_cmp

  logic [31:0] dev_mag;
  logic [31:0] spd_mag;
  logic [31:0] cmd_mag;
  assign dev_mag = abs32(deviation_in);
  assign spd_mag = abs32(CW'(motor_speed_in));
  assign cmd_mag = abs32(CW'(speed_cmd_in));

  logic done_reg;
  logic near_reg;
  logic spd_reg;
  logic trq_reg;
  logic zero_reg;
  logic static_reg;

  // Zero speed band: set below the point, released only at point plus hysteresis.
  function automatic logic cur_zero(input logic [31:0] mag);
    cur_zero = zero_reg ? (mag < CW'(cfg_in.zero_speed_point) + CW'(cfg_in.zero_speed_hysteresis))
                        : (mag < CW'(cfg_in.zero_speed_point));
  endfunction : cur_zero

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_reg <= 1'b0;
      near_reg <= 1'b0;
    end else if (clk_en_in) begin
      done_reg <= pos_mode_in &&
        below_hyst(dev_mag, CW'(cfg_in.done_range), CW'(cfg_in.done_hysteresis), done_reg);
      near_reg <= pos_mode_in &&
        below_hyst(dev_mag, CW'(cfg_in.approach_range), CW'(cfg_in.approach_hysteresis), near_reg);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      spd_reg <= 1'b0;
      trq_reg <= 1'b0;
      zero_reg <= 1'b0;
      static_reg <= 1'b0;
    end else if (clk_en_in) begin
      spd_reg <= reach_cmp(CW'(motor_speed_in), CW'(cfg_in.speed_reach_threshold),
                           $signed(CW'(cfg_in.speed_reach_hysteresis)), cfg_in.speed_reach_polarity, spd_reg);
      trq_reg <= reach_cmp(CW'(motor_torque_in), CW'(cfg_in.torque_reach_threshold),
                           $signed(CW'(cfg_in.torque_reach_hysteresis)), cfg_in.torque_reach_polarity, trq_reg);
      // Zero speed held until speed reaches point plus hysteresis.
      zero_reg <= cur_zero(spd_mag);
      // Stationary judgement, used by the brake sequencer and the dynamic brake enable.
      static_reg <= (spd_mag < CW'(cfg_in.static_speed_point));
    end
  end

  assign position_done_flag = done_reg;
  assign near_position_flag = near_reg;
  assign speed_reached_flag = spd_reg;
  assign torque_reached_flag = trq_reg;
  assign standstill_speed_flag = zero_reg;

  // Clamp needs all three conditions together.
  logic clamp_cond;
  assign clamp_cond = speed_mode_in && zero_hold_input && (cmd_mag < CW'(cfg_in.zero_speed_point));

  logic clamp_reg;
  logic signed [31:0] clamp_pos_reg;
  logic signed [15:0] cmd_reg;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clamp_reg <= 1'b0;
      clamp_pos_reg <= '0;
      cmd_reg <= '0;
    end else if (clk_en_in) begin
      clamp_reg <= clamp_cond;
      if (clamp_cond && !clamp_reg) begin
        clamp_pos_reg <= motor_pos_in;
      end
      cmd_reg <= (clamp_cond && cfg_in.zero_hold_mode) ? 16'sh0000 : speed_cmd_in;
    end
  end
  assign clamp_active_out = clamp_reg;
  assign clamp_pos_hold_out = clamp_reg && !cfg_in.zero_hold_mode;
  assign clamp_pos_out = clamp_pos_reg;
  assign speed_cmd_out = cmd_reg;

  logic clear_prev_reg;
  logic clear_pulse_reg;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clear_prev_reg <= 1'b0;
      clear_pulse_reg <= 1'b0;
    end else if (clk_en_in) begin
      clear_prev_reg <= deviation_clear_input;
      // Rising-edge clear in position mode, clear mode 1 only.
      clear_pulse_reg <= pos_mode_in && cfg_in.deviation_clear_mode && deviation_clear_input && !clear_prev_reg;
    end
  end
  assign deviation_clear_out = clear_pulse_reg;

  // Brake and current sequencer.
  sssl_pkg::sssl_state_t state_reg;
  logic [31:0] cnt_reg;
  logic [31:0] still_cyc;
  logic [31:0] run_cyc;
  assign still_cyc = CW'(cfg_in.standstill_brake_delay) * CW'(CYC_PER_MS);
  assign run_cyc = CW'(cfg_in.running_brake_wait) * CW'(CYC_PER_MS);

  logic stop_req;
  logic estop_coast;
  assign stop_req = !servo_on_input || alarm_in;
  // Mode 0 emergency drops current immediately.
  assign estop_coast = emergency_stop_input && (cfg_in.emergency_stop_mode == sssl_pkg::ESTOP_COAST);

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= sssl_pkg::SSSL_OFF;
      cnt_reg <= '0;
    end else if (clk_en_in) begin
      case (state_reg)
        sssl_pkg::SSSL_OFF: begin
          cnt_reg <= '0;
          if (!stop_req) state_reg <= sssl_pkg::SSSL_ON;
        end
        sssl_pkg::SSSL_ON: begin
          cnt_reg <= '0;
          if (stop_req) state_reg <= static_reg ? sssl_pkg::SSSL_STOP_STILL : sssl_pkg::SSSL_STOP_RUN;
        end
        // Brake first, current off after standstill delay.
        sssl_pkg::SSSL_STOP_STILL: begin
          cnt_reg <= cnt_reg + 32'h00000001;
          if (cnt_reg + 32'h00000001 >= still_cyc) state_reg <= sssl_pkg::SSSL_OFF;
        end
        // Current off first, brake after wait or at brake speed.
        sssl_pkg::SSSL_STOP_RUN: begin
          cnt_reg <= cnt_reg + 32'h00000001;
          if (cnt_reg >= run_cyc || spd_mag <= CW'(cfg_in.running_brake_speed)) state_reg <= sssl_pkg::SSSL_OFF;
        end
        default: state_reg <= sssl_pkg::SSSL_OFF;
      endcase
    end
  end

  logic cur_reg;
  logic release_reg;
  logic ramp_reg;
  logic dyn_reg;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur_reg <= 1'b0;
      release_reg <= 1'b0;
      ramp_reg <= 1'b0;
      dyn_reg <= 1'b0;
    end else if (clk_en_in) begin
      cur_reg <= (state_reg == sssl_pkg::SSSL_ON || state_reg == sssl_pkg::SSSL_STOP_STILL) && !estop_coast;
      release_reg <= (state_reg == sssl_pkg::SSSL_ON) || (state_reg == sssl_pkg::SSSL_STOP_RUN);
      // Every mode but 0 (modes 1 to 3) keeps current and raises the ramp stop output.
      ramp_reg <= emergency_stop_input && (cfg_in.emergency_stop_mode != sssl_pkg::ESTOP_COAST);
      dyn_reg <= (cfg_in.dyn_brake_delay != 12'h000) && !cur_reg && !static_reg;
    end
  end
  assign current_on_out = cur_reg;
  assign brake_release_output = release_reg;
  assign ramp_stop_out = ramp_reg;
  assign dyn_brake_en_out = dyn_reg;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_dyn_brake_off: assert property (clk_en_in && cfg_in.dyn_brake_delay == 12'h000 |=> !dyn_brake_en_out)
    else $error("dynamic brake active with zero delay");
  a_done_needs_pos: assert property (clk_en_in && !pos_mode_in |=> !position_done_flag)
    else $error("done flag outside position mode");
  a_near_set: assert property (clk_en_in && pos_mode_in && dev_mag <= CW'(cfg_in.approach_range)
    |=> near_position_flag)
    else $error("near flag not set");
  a_speed_reach: assert property (clk_en_in && !cfg_in.speed_reach_polarity
    && spd_mag > abs32(CW'(cfg_in.speed_reach_threshold)) |=> speed_reached_flag)
    else $error("speed reached flag not set");
  a_torque_reach: assert property (clk_en_in && !cfg_in.torque_reach_polarity
    && abs32(CW'(motor_torque_in)) > abs32(CW'(cfg_in.torque_reach_threshold)) |=> torque_reached_flag)
    else $error("torque reached flag not set");
  a_zero_set: assert property (clk_en_in && spd_mag < CW'(cfg_in.zero_speed_point)
    |=> standstill_speed_flag)
    else $error("zero speed flag not set");
  a_zero_hold: assert property (clk_en_in && zero_reg
    && spd_mag < CW'(cfg_in.zero_speed_point) + CW'(cfg_in.zero_speed_hysteresis)
    |=> standstill_speed_flag)
    else $error("zero speed released inside hysteresis");
  a_zero_release: assert property (clk_en_in
    && spd_mag >= CW'(cfg_in.zero_speed_point) + CW'(cfg_in.zero_speed_hysteresis)
    |=> !standstill_speed_flag)
    else $error("zero speed held past hysteresis");
  a_clamp_capture: assert property (clk_en_in && clamp_cond && !clamp_reg
    |=> clamp_pos_out == $past(motor_pos_in))
    else $error("clamp position not captured on entry");
  a_clamp_zero: assert property (clk_en_in && clamp_cond && cfg_in.zero_hold_mode
    |=> speed_cmd_out == 16'sh0000)
    else $error("clamp did not zero command");
  a_clear_edge: assert property (deviation_clear_out |-> $past(!deviation_clear_input, 2))
    else $error("clear pulse without rising edge");
  a_clear_refused: assert property (clk_en_in && !(pos_mode_in && cfg_in.deviation_clear_mode)
    |=> !deviation_clear_out)
    else $error("clear pulse while clearing is refused");
  a_coast_now: assert property (clk_en_in && estop_coast |=> !current_on_out)
    else $error("current still on in coast stop");
  a_ramp_modes: assert property (clk_en_in && emergency_stop_input
    && cfg_in.emergency_stop_mode != sssl_pkg::ESTOP_COAST |=> ramp_stop_out)
    else $error("no ramp stop in emergency ramp mode");
  a_still_brake: assert property (state_reg == sssl_pkg::SSSL_STOP_STILL && clk_en_in
    |=> !brake_release_output)
    else $error("brake not engaged at standstill stop");
  a_still_current: assert property (clk_en_in && state_reg == sssl_pkg::SSSL_STOP_STILL && !estop_coast
    |=> current_on_out)
    else $error("current dropped before standstill delay");
  a_run_current: assert property (clk_en_in && state_reg == sssl_pkg::SSSL_STOP_RUN
    |=> !current_on_out)
    else $error("current still on in running stop");
  c_clamp: cover property (clamp_reg && !cfg_in.zero_hold_mode);
  c_still: cover property (state_reg == sssl_pkg::SSSL_STOP_STILL);
  c_run: cover property (state_reg == sssl_pkg::SSSL_STOP_RUN);
  c_clear: cover property (deviation_clear_out);
  c_ramp: cover property (ramp_stop_out);
endmodule : sssl_top

// [test/sssl_host_model.sv]
// Host model: programs the status settings and counts cycles of the clear pulse.
`timescale 1ns/1ps
module sssl_host_model (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic deviation_clear_out,
  output sssl_pkg::sssl_cfg_t cfg_out,
  output int pulse_cycles_out
);
  // Approach range set wider than done range, so near warns first.
  always_comb begin
    cfg_out = '0;
    cfg_out.done_range = 15'h000A;
    cfg_out.done_hysteresis = 15'h0005;
    cfg_out.approach_range = 15'h01F4;
    cfg_out.approach_hysteresis = 15'h0032;
    cfg_out.speed_reach_hysteresis = 16'h0014;
    cfg_out.torque_reach_hysteresis = 16'h0014;
    cfg_out.zero_speed_point = 16'h000A;
    cfg_out.zero_speed_hysteresis = 16'h0005;
    cfg_out.static_speed_point = 16'h0005;
    cfg_out.standstill_brake_delay = 12'h003;
    cfg_out.running_brake_speed = 16'h0064;
  end
  // Counting high cycles rather than edges, so a stretched pulse shows up.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pulse_cycles_out <= 0;
    end else if (deviation_clear_out) begin
      pulse_cycles_out <= pulse_cycles_out + 1;
    end
  end
endmodule : sssl_host_model

// [test/tb.sv]
// Self-checking bench for the servo status and stop logic.
`timescale 1ns/1ps
module tb;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic pm = 1'b0, sm = 1'b0, zh = 1'b0, dclr = 1'b0, estop = 1'b0, srv = 1'b0, alm = 1'b0, ce = 1'b1;
  logic signed [31:0] dev = '0, mpos = '0, cl_pos;
  logic signed [15:0] spd = '0, cmd = '0, cmd_o;
  sssl_pkg::sssl_cfg_t c = '0, base;
  logic done_f, near_f, spd_f, trq_f, zero_f, cl_act, cl_hold, dclr_p, cur, ramp, dyn, rel;
  int pulses, n, failures = 0, samples_checked = 0;
  int dvt[8] = '{600, 14, -10, 15, 16, 550, 551, 0};
  bit edn[8] = '{0, 0, 1, 1, 0, 0, 0, 0};
  bit enr[8] = '{0, 1, 1, 1, 1, 1, 0, 0};
  int sv[13] = '{0, 12, 15, 10, -9, 201, 185, 180, -201, -250, 250, 250, -250};
  bit sr[13] = '{0, 0, 0, 0, 0, 1, 1, 0, 1, 0, 1, 0, 1};
  bit sz[13] = '{1, 1, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0};
  always #5 ref_clk_in = ~ref_clk_in;
  sssl_top #(.CYC_PER_MS(10)) DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .clk_en_in(ce), .cfg_in(c),
    .pos_mode_in(pm), .speed_mode_in(sm), .deviation_in(dev), .motor_speed_in(spd), .motor_torque_in(spd),
    .speed_cmd_in(cmd), .motor_pos_in(mpos), .zero_hold_input(zh), .deviation_clear_input(dclr),
    .emergency_stop_input(estop), .servo_on_input(srv), .alarm_in(alm), .position_done_flag(done_f),
    .near_position_flag(near_f), .speed_reached_flag(spd_f), .torque_reached_flag(trq_f),
    .standstill_speed_flag(zero_f), .clamp_active_out(cl_act), .clamp_pos_hold_out(cl_hold),
    .clamp_pos_out(cl_pos), .speed_cmd_out(cmd_o), .deviation_clear_out(dclr_p), .current_on_out(cur),
    .ramp_stop_out(ramp), .dyn_brake_en_out(dyn), .brake_release_output(rel));
  sssl_host_model host (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .deviation_clear_out(dclr_p),
    .cfg_out(base), .pulse_cycles_out(pulses));
  task automatic check(input logic [63:0] s, input logic [63:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("Error at %0t seen %0h expected %0h", $time, s, e);
    end
  endtask : check
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask : step
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  // A wait that used up its bound is a hang; stop here rather than run on.
  task automatic bound(input int lim);
    if (n >= lim) begin
      failures++;
      wrap_up();
    end
  endtask : bound
  initial begin
    step(6);
    check({cur, rel, done_f, dclr_p}, '0);
    rst_n_in = 1'b1;
    c = base;
    step(2);
    for (int i = 0; i < 8; i++) begin
      dev = 32'(dvt[i]);
      pm = (i != 7);
      step(3);
      check(done_f, edn[i]);
      check(near_f, enr[i]);
    end
    // A low clock enable must freeze the flags even though the inputs call for a change.
    ce = 1'b0;
    pm = 1'b1;
    step(3);
    check(done_f, 1'b0);
    ce = 1'b1;
    step(2);
    check(done_f, 1'b1);
    $display("test position flags finished");
    for (int i = 0; i < 13; i++) begin
      c.speed_reach_polarity = (i > 8);
      c.torque_reach_polarity = (i > 8);
      c.speed_reach_threshold = (i > 10) ? -16'sh00C8 : 16'sh00C8;
      c.torque_reach_threshold = c.speed_reach_threshold;
      spd = 16'(sv[i]);
      step(3);
      check(spd_f, sr[i]);
      check(trq_f, sr[i]);
      check(zero_f, sz[i]);
    end
    $display("test reach flags finished");
    spd = '0;
    sm = 1'b1;
    zh = 1'b1;
    c.zero_hold_mode = 1'b1;
    cmd = 16'sh0005;
    step(3);
    check({cl_act, cl_hold, cmd_o}, {2'b10, 16'h0000});
    cmd = 16'sh000A;
    step(3);
    check({cl_act, cmd_o}, {1'b0, 16'h000A});
    c.zero_hold_mode = 1'b0;
    mpos = 32'h000004D2;
    cmd = -16'sh0005;
    step(3);
    check({cl_act, cl_hold, cl_pos}, {2'b11, 32'h000004D2});
    mpos = 32'h000007D0;
    sm = 1'b0;
    step(3);
    check({cl_act, cl_pos}, {1'b0, 32'h000004D2});
    $display("test zero hold finished");
    // Pass 2 is refused for lack of position mode, pass 1 clears, pass 0 is refused by the clear mode.
    for (int m = 2; m >= 0; m--) begin
      c.deviation_clear_mode = (m != 0);
      pm = (m != 2);
      n = pulses;
      dclr = 1'b1;
      step(5);
      dclr = 1'b0;
      step(2);
      check(pulses - n, m == 1);
    end
    pm = 1'b1;
    $display("test deviation clear finished");
    for (int k = 0; k < 2; k++) begin
      srv = 1'b1;
      step(4);
      check({cur, rel}, 2'b11);
      alm = (k == 1);
      srv = (k == 1);
      step(3);
      check({cur, rel, dyn}, 3'b100);
      for (n = 0; n < 60 && cur !== 1'b0; n++) step(1);
      bound(60);
      check(n inside {[26:32]}, 1'b1);
      srv = 1'b0;
      alm = 1'b0;
      step(3);
    end
    for (int k = 0; k < 2; k++) begin
      spd = 16'sh03E8;
      c.running_brake_wait = k ? 12'h064 : 12'h002;
      c.dyn_brake_delay = k ? 12'h000 : 12'h064;
      srv = 1'b1;
      step(4);
      srv = 1'b0;
      step(3);
      check({cur, rel, dyn}, {2'b01, k == 0});
      spd = k ? 16'sh0032 : 16'sh03E8;
      for (n = 0; n < 60 && rel !== 1'b0; n++) step(1);
      bound(60);
      check(k ? (n < 4) : (n inside {[15:21]}), 1'b1);
    end
    spd = '0;
    step(5);
    $display("test brake sequence finished");
    for (int m = 0; m < 3; m++) begin
      c.emergency_stop_mode = 2'(m);
      srv = 1'b1;
      step(4);
      estop = 1'b1;
      step(4);
      check({cur, ramp}, {2{m != 0}});
      estop = 1'b0;
      srv = 1'b0;
      step(60);
    end
    $display("test emergency stop finished");
    wrap_up();
  end
endmodule : tb
